// File: include/speed_ramp_pkg.sv
// Purpose: shared constants and types for the speed ramp and limiter
// Assumes: 100 MHz control clock, 1 ms ramp tick, analog reference in mV
// Notes:   speeds in rpm, gain in tenths of rpm per volt
package speed_ramp_pkg;

	// clock and tick timing
	localparam int unsigned CLK_PERIOD_NS  = 10;      // control clock period
	localparam int unsigned TICK_PERIOD_US = 1000;    // ramp tick, one ms
	localparam int unsigned TICK_CYCLES    = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;

	// setting ranges and defaults
	localparam logic [15:0] ACCEL_MAX_MS   = 16'hEA60; // 60000 ms
	localparam logic [15:0] ACCEL_DEF_MS   = 16'h0000;
	localparam logic [15:0] DECEL_DEF_MS   = 16'h0000;
	localparam logic [12:0] SCURVE_MAX_MS  = 13'h1388; // 5000 ms
	localparam logic [12:0] SCURVE_DEF_MS  = 13'h0000;
	localparam logic [12:0] LIMIT_MAX_RPM  = 13'h1388; // 5000 rpm
	localparam logic [12:0] LIMIT_MIN_RPM  = 13'h0001;
	localparam logic [14:0] GAIN_MIN       = 15'h0064; // 10.0 rpm/V
	localparam logic [14:0] GAIN_MAX       = 15'h4E20; // 2000.0 rpm/V
	localparam logic [14:0] GAIN_DEF       = 15'h1388; // 500.0 rpm/V

	// analog reference scaling: rpm = gain_tenths * mv / 10000
	localparam logic signed [15:0] REF_MAX_MV = 16'sh2710; // +10 V
	localparam logic signed [31:0] EXT_DIV    = 32'sh00002710;

	// fixed point and divider
	localparam int unsigned FRAC_BITS = 16;
	localparam int unsigned DIV_WIDTH = 32;
	localparam int unsigned DIV_CNT_W = 6;

	// speed limit selection codes
	typedef enum logic [1:0] {
		LIM_NONE     = 2'h0,
		LIM_INTERNAL = 2'h1,
		LIM_EXTERNAL = 2'h2,
		LIM_SMALLER  = 2'h3
	} limit_sel_t;

	// control modes
	typedef enum logic [1:0] {
		MODE_POSITION  = 2'h0,
		MODE_SPEED     = 2'h1,
		MODE_TORQUE    = 2'h2,
		MODE_MULTISTEP = 2'h3
	} ctrl_mode_t;

endpackage

// File: core/step_divider.sv
// Purpose: unsigned restoring divider, one quotient bit per clock
// Assumes: start_i is a one-cycle pulse; operands held by the divider
// Notes:   divide by zero yields all ones; done_o pulses when ready
`timescale 1ns/1ps
module step_divider (
	// clock and reset
	input  wire logic                                  clock_i,
	input  wire logic                                  resetn_i,
	// request
	input  wire logic                                  start_i,
	input  wire logic [speed_ramp_pkg::DIV_WIDTH-1:0]  dividend_i,
	input  wire logic [speed_ramp_pkg::DIV_WIDTH-1:0]  divisor_i,
	// answer
	output logic      [speed_ramp_pkg::DIV_WIDTH-1:0]  quotient_o,
	output logic                                       done_o
);
	localparam int unsigned W = speed_ramp_pkg::DIV_WIDTH;

	logic [W-1:0]                            rem_q;  // partial remainder
	logic [W-1:0]                            quo_q;  // dividend shifting to quotient
	logic [W-1:0]                            den_q;  // held divisor
	logic [speed_ramp_pkg::DIV_CNT_W-1:0]    cnt_q;  // bits still to do
	logic                                    done_q; // result ready pulse
	logic [W:0]                              trial;  // trial subtraction

	// trial subtract of the shifted remainder
	assign trial = {rem_q, quo_q[W-1]} - {1'b0, den_q};

	// shift and subtract sequence
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			rem_q  <= '0;
			quo_q  <= '0;
			den_q  <= '0;
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start_i) begin
				rem_q <= '0;
				quo_q <= dividend_i;
				den_q <= divisor_i;
				cnt_q <= speed_ramp_pkg::DIV_CNT_W'(W);
			end else if (cnt_q != '0) begin
				// subtract fits: keep it and set quotient bit
				if (!trial[W]) begin
					rem_q <= trial[W-1:0];
					quo_q <= {quo_q[W-2:0], 1'b1};
				end else begin
					rem_q <= {rem_q[W-2:0], quo_q[W-1]};
					quo_q <= {quo_q[W-2:0], 1'b0};
				end
				cnt_q <= cnt_q - 1'b1;
				if (cnt_q == speed_ramp_pkg::DIV_CNT_W'(1)) begin
					done_q <= 1'b1;
				end
			end
		end
	end

	assign quotient_o = quo_q;
	assign done_o     = done_q;
endmodule

// File: core/speed_ramp_limiter.sv
// Purpose: speed command ramp, S-curve rounding and speed limiting
// Assumes: settings come from the configuration logic on the same clock
// Notes:   ramp steps are recomputed every tick and apply from the next
//
// Summary of operation
// - accel time 0..60000 ms, default zero
// - decel time 0..60000 ms, default zero
// - S-curve time 0..5000 ms, default zero
// - zero S-curve time gives plain linear ramps
// - nonzero S-curve rounds slope changes, not zero-time ramps or reversals
// - shaped command ends later than raw command
// - internal limit 1..5000 rpm clamps speed
// - motor configuration loads motor max speed
// - non-speed modes use analog input as limit
// - speed mode allows internal limit only
// - external limit equals gain times voltage
// - analog sign gives rotation direction
// - external limit symmetric, sign ignored
// - select: none, internal, external, smaller
`timescale 1ns/1ps
module speed_ramp_limiter #(
	parameter int unsigned TICK_CYCLES = speed_ramp_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic               clock_i,
	input  wire logic               resetn_i,
	// settings
	input  wire logic               setting_load_i,
	input  wire logic [15:0]        accel_time_setting_i,
	input  wire logic [15:0]        decel_time_setting_i,
	input  wire logic [12:0]        scurve_time_setting_i,
	input  wire logic [12:0]        internal_limit_setting_i,
	input  wire logic [14:0]        external_gain_setting_i,
	input  wire logic [1:0]         limit_select_setting_i,
	// drive state
	input  wire logic [1:0]         control_mode_i,
	input  wire logic               servo_enable_i,
	input  wire logic               motor_config_i,
	input  wire logic [12:0]        motor_max_speed_i,
	input  wire logic [12:0]        rated_speed_i,
	// commands
	input  wire logic signed [15:0] speed_cmd_i,
	input  wire logic signed [15:0] analog_ref_i,
	// results
	output logic signed [15:0]      speed_out_o,
	output logic                    ramp_busy_o,
	output logic                    limit_active_o,
	output logic [12:0]             internal_limit_o
);
	// package constants under local names
	localparam logic [15:0]        ACCEL_MAX_MS  = speed_ramp_pkg::ACCEL_MAX_MS;
	localparam logic [15:0]        ACCEL_DEF_MS  = speed_ramp_pkg::ACCEL_DEF_MS;
	localparam logic [15:0]        DECEL_DEF_MS  = speed_ramp_pkg::DECEL_DEF_MS;
	localparam logic [12:0]        SCURVE_MAX_MS = speed_ramp_pkg::SCURVE_MAX_MS;
	localparam logic [12:0]        SCURVE_DEF_MS = speed_ramp_pkg::SCURVE_DEF_MS;
	localparam logic [12:0]        LIMIT_MAX_RPM = speed_ramp_pkg::LIMIT_MAX_RPM;
	localparam logic [12:0]        LIMIT_MIN_RPM = speed_ramp_pkg::LIMIT_MIN_RPM;
	localparam logic [14:0]        GAIN_MIN      = speed_ramp_pkg::GAIN_MIN;
	localparam logic [14:0]        GAIN_MAX      = speed_ramp_pkg::GAIN_MAX;
	localparam logic [14:0]        GAIN_DEF      = speed_ramp_pkg::GAIN_DEF;
	localparam logic signed [15:0] REF_MAX_MV    = speed_ramp_pkg::REF_MAX_MV;
	localparam logic signed [31:0] EXT_DIV       = speed_ramp_pkg::EXT_DIV;
	localparam logic [1:0]         MODE_SPEED    = speed_ramp_pkg::MODE_SPEED;
	// selection type and codes
	typedef speed_ramp_pkg::limit_sel_t limit_sel_t;
	localparam limit_sel_t         LIM_NONE      = speed_ramp_pkg::LIM_NONE;
	localparam limit_sel_t         LIM_INTERNAL  = speed_ramp_pkg::LIM_INTERNAL;
	localparam limit_sel_t         LIM_EXTERNAL  = speed_ramp_pkg::LIM_EXTERNAL;
	localparam limit_sel_t         LIM_SMALLER   = speed_ramp_pkg::LIM_SMALLER;

	logic [16:0]        tick_cnt_q;    // tick divider
	logic               tick_q;        // one ms enable
	logic [15:0]        accel_ms_q;    // held accel time
	logic [15:0]        decel_ms_q;    // held decel time
	logic [12:0]        scurve_ms_q;   // held S-curve time
	logic [12:0]        int_lim_q;     // internal limit rpm
	logic [14:0]        gain_q;        // external gain, tenths
	limit_sel_t         sel_q;         // limit selection
	logic               speed_mode;    // analog carries the command
	logic signed [15:0] ref_mv;        // clamped analog sample
	logic signed [31:0] prod;          // gain times voltage
	logic [31:0]        prod_abs;      // magnitude of prod
	logic signed [15:0] analog_rpm;    // analog speed command
	logic [15:0]        ext_lim;       // external limit rpm
	logic signed [31:0] target_q;      // ramp target, fixed point
	logic signed [31:0] speed_q;       // ramped speed, fixed point
	logic [31:0]        slope_q;       // current step under S-curve
	logic [31:0]        full_q;        // full step last used
	logic               dir_q;         // last ramp direction, 1 down
	logic [31:0]        div_num [3];   // divider dividends
	logic [31:0]        div_den [3];   // divider divisors
	logic [31:0]        div_quo [3];   // divider quotients
	logic               div_done [3];  // divider done pulses
	logic [31:0]        step_q [3];    // accel, decel and jerk steps

	// tick divider: one enable pulse per ms
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else begin
			tick_q     <= (tick_cnt_q == 17'(TICK_CYCLES - 1));
			tick_cnt_q <= (tick_cnt_q == 17'(TICK_CYCLES - 1)) ? '0 : tick_cnt_q + 1'b1;
		end
	end

	// ramp times, may change at any time
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			accel_ms_q  <= ACCEL_DEF_MS;
			decel_ms_q  <= DECEL_DEF_MS;
			scurve_ms_q <= SCURVE_DEF_MS;
		end else if (setting_load_i) begin
			accel_ms_q  <= (accel_time_setting_i > ACCEL_MAX_MS) ?
				ACCEL_MAX_MS : accel_time_setting_i;
			decel_ms_q  <= (decel_time_setting_i > ACCEL_MAX_MS) ?
				ACCEL_MAX_MS : decel_time_setting_i;
			scurve_ms_q <= (scurve_time_setting_i > SCURVE_MAX_MS) ?
				SCURVE_MAX_MS : scurve_time_setting_i;
		end
	end

	// limit settings taken only with the servo off; motor max speed loads at any time
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			int_lim_q <= LIMIT_MAX_RPM;
			gain_q    <= GAIN_DEF;
			sel_q     <= LIM_NONE;
		end else if (motor_config_i) begin
			int_lim_q <= (motor_max_speed_i > LIMIT_MAX_RPM) ? LIMIT_MAX_RPM :
				(motor_max_speed_i < LIMIT_MIN_RPM) ? LIMIT_MIN_RPM : motor_max_speed_i;
		end else if (setting_load_i && !servo_enable_i) begin
			int_lim_q <= (internal_limit_setting_i > LIMIT_MAX_RPM) ? LIMIT_MAX_RPM :
				(internal_limit_setting_i < LIMIT_MIN_RPM) ? LIMIT_MIN_RPM :
				internal_limit_setting_i;
			gain_q    <= (external_gain_setting_i > GAIN_MAX) ? GAIN_MAX :
				(external_gain_setting_i < GAIN_MIN) ? GAIN_MIN : external_gain_setting_i;
			sel_q     <= limit_sel_t'(limit_select_setting_i);
		end
	end

	// analog scaling: command in speed mode, limit otherwise
	always_comb begin
		speed_mode = (control_mode_i == MODE_SPEED);
		// span clamp, sign kept for direction
		if (analog_ref_i > REF_MAX_MV) begin
			ref_mv = REF_MAX_MV;
		end else if (analog_ref_i < -REF_MAX_MV) begin
			ref_mv = -REF_MAX_MV;
		end else begin
			ref_mv = analog_ref_i;
		end
		prod       = {17'h0, gain_q} * {{16{ref_mv[15]}}, ref_mv};
		analog_rpm = 16'(prod / EXT_DIV);
		prod_abs   = prod[31] ? 32'(-prod) : 32'(prod);
		ext_lim    = 16'(prod_abs / 32'(EXT_DIV));
	end

	// ramp target from the active command source
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			target_q <= '0;
		end else begin
			target_q <= {(speed_mode ? analog_rpm : speed_cmd_i), 16'h0000};
		end
	end

	// step dividers: rated/accel, rated/decel, full step/S-curve
	assign div_num[0] = {3'h0, rated_speed_i, 16'h0000};
	assign div_num[1] = {3'h0, rated_speed_i, 16'h0000};
	assign div_num[2] = full_q;
	assign div_den[0] = {16'h0000, accel_ms_q};
	assign div_den[1] = {16'h0000, decel_ms_q};
	assign div_den[2] = {19'h00000, scurve_ms_q};

	generate
		for (genvar ch = 0; ch < 3; ch++) begin : g_div
			step_divider u_div (
				.clock_i    (clock_i),
				.resetn_i   (resetn_i),
				.start_i    (tick_q),
				.dividend_i (div_num[ch]),
				.divisor_i  (div_den[ch]),
				.quotient_o (div_quo[ch]),
				.done_o     (div_done[ch])
			);
			// hold the latest quotient
			always_ff @(posedge clock_i) begin
				if (!resetn_i) begin
					step_q[ch] <= '0;
				end else if (div_done[ch]) begin
					step_q[ch] <= div_quo[ch];
				end
			end
		end
	endgenerate

	// ramp decisions for this tick
	logic signed [32:0] diff;       // target minus speed
	logic [32:0]        diff_abs;   // distance to go
	logic               accel;      // moving away from zero
	logic [15:0]        ramp_ms;    // time of the active ramp
	logic [31:0]        full_step;  // linear step of the active ramp
	logic [31:0]        jerk;       // slope change per tick
	logic               s_on;       // S-curve rounding active
	logic               brake;      // slope must wind down
	logic [31:0]        slope_nxt;  // slope for this tick
	logic [31:0]        step_use;   // step actually applied
	logic               arrive;     // target reached this tick

	always_comb begin
		diff      = {target_q[31], target_q} - {speed_q[31], speed_q};
		diff_abs  = diff[32] ? 33'(-diff) : 33'(diff);
		accel     = (!speed_q[31] && !diff[32] && diff != '0) ||
			((speed_q[31] || speed_q == '0) && diff[32]);
		ramp_ms   = accel ? accel_ms_q : decel_ms_q;
		full_step = accel ? step_q[0] : step_q[1];
		jerk      = (step_q[2] == '0) ? 32'h00000001 : step_q[2];
		s_on      = (scurve_ms_q != '0);
		brake     = ({16'h0000, slope_q} * {35'h0, scurve_ms_q}) >=
			{14'h0000, diff_abs, 1'b0};
		// slope rises and falls by jerk
		if (!s_on || dir_q != diff[32]) begin
			slope_nxt = '0;
		end else if (brake) begin
			slope_nxt = (slope_q > jerk) ? slope_q - jerk : jerk;
		end else if (slope_q + jerk < full_step) begin
			slope_nxt = slope_q + jerk;
		end else begin
			slope_nxt = full_step;
		end
		// linear step when S-curve is off
		step_use  = s_on ? ((slope_nxt == '0) ? jerk : slope_nxt) : full_step;
		arrive    = (ramp_ms == '0) || (diff_abs <= {1'b0, step_use});
	end

	// ramp speed toward target each tick
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			speed_q <= '0;
			slope_q <= '0;
			full_q  <= '0;
			dir_q   <= 1'b0;
		end else if (tick_q) begin
			full_q  <= full_step;
			dir_q   <= diff[32];
			if (arrive) begin
				speed_q <= target_q;
				slope_q <= '0;
			end else begin
				speed_q <= diff[32] ? speed_q - $signed(step_use) : speed_q + $signed(step_use);
				slope_q <= slope_nxt;
			end
		end
	end

	// limit value from the selection
	logic [15:0]        lim_val;    // applied limit rpm
	logic               lim_on;     // a limit applies
	logic signed [15:0] spd_int;    // integer part of speed

	always_comb begin
		spd_int = speed_q[31:16];
		lim_val = {3'h0, int_lim_q};
		case (sel_q)
			LIM_NONE: begin
				lim_on = 1'b0;
			end
			LIM_INTERNAL: begin
				lim_on = 1'b1;
			end
			LIM_EXTERNAL: begin
				lim_on  = !speed_mode;
				lim_val = ext_lim;
			end
			LIM_SMALLER: begin
				lim_on = 1'b1;
				if (!speed_mode && ext_lim < {3'h0, int_lim_q}) begin
					lim_val = ext_lim;
				end
			end
			default: begin
				lim_on = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			speed_out_o    <= '0;
			limit_active_o <= 1'b0;
			ramp_busy_o    <= 1'b0;
		end else begin
			ramp_busy_o <= (speed_q != target_q);
			if (lim_on && !spd_int[15] && $unsigned(spd_int) > lim_val) begin
				speed_out_o    <= $signed(lim_val);
				limit_active_o <= 1'b1;
			end else if (lim_on && spd_int[15] && $unsigned(-spd_int) > lim_val) begin
				speed_out_o    <= -$signed(lim_val);
				limit_active_o <= 1'b1;
			end else begin
				speed_out_o    <= spd_int;
				limit_active_o <= 1'b0;
			end
		end
	end

	assign internal_limit_o = int_lim_q;

	// checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	sequence s_linear_tick;
		tick_q && !s_on && ramp_ms != '0 && !arrive && !diff[32];
	endsequence

	a_accel_in_range: assert property (accel_ms_q <= ACCEL_MAX_MS)
		else $error("accel time out of range");
	a_decel_in_range: assert property (decel_ms_q <= ACCEL_MAX_MS)
		else $error("decel time out of range");
	a_scurve_in_range: assert property (scurve_ms_q <= SCURVE_MAX_MS)
		else $error("s-curve time out of range");
	a_linear_ramp_step: assert property (s_linear_tick |=>
		speed_q == $past(speed_q) + $signed($past(full_step)))
		else $error("linear ramp step wrong");
	a_scurve_slope_soft: assert property (tick_q && s_on && !arrive |=>
		slope_q <= $past(slope_q) + $past(jerk))
		else $error("s-curve slope jumped");
	a_zero_time_pass: assert property (tick_q && accel_ms_q == '0 &&
		decel_ms_q == '0 |=> speed_q == $past(target_q))
		else $error("zero ramp time did not pass target");
	a_internal_clamp: assert property (sel_q == LIM_INTERNAL ##1
		sel_q == LIM_INTERNAL |-> (speed_out_o[15] ? -speed_out_o : speed_out_o)
		<= $signed({3'h0, $past(int_lim_q)}))
		else $error("internal limit exceeded");
	a_motor_default: assert property (motor_config_i && motor_max_speed_i != '0 &&
		motor_max_speed_i <= LIMIT_MAX_RPM |=> int_lim_q == $past(motor_max_speed_i))
		else $error("motor max speed not loaded");
	a_speed_mode_noext: assert property (sel_q == LIM_EXTERNAL && speed_mode |=>
		speed_out_o == $past(spd_int))
		else $error("external limit used in speed mode");
	a_no_limit_pass: assert property (sel_q == LIM_NONE |=>
		speed_out_o == $past(spd_int) && !limit_active_o)
		else $error("limit applied with selection none");
	a_analog_direction: assert property (speed_mode && analog_ref_i > 16'sh0064
		|=> !target_q[31])
		else $error("positive reference gave reverse");
	a_ext_symmetric: assert property (!speed_mode && sel_q == LIM_EXTERNAL
		&& limit_active_o |-> speed_out_o == $signed($past(lim_val))
		|| speed_out_o == -$signed($past(lim_val)))
		else $error("external limit not symmetric");
endmodule

// File: tb/host_model.sv
// Purpose: host side stand-in driving settings, drive state and commands
// Assumes: caller is aligned 1 ns after a rising clock edge
// Notes:   changes always land 1 ns after the edge
`timescale 1ns/1ps
module host_model (
	// clock
	input  wire logic               clock_i,
	// settings
	output logic                    setting_load_o,
	output logic [15:0]             accel_o,
	output logic [15:0]             decel_o,
	output logic [12:0]             scurve_o,
	output logic [12:0]             limit_o,
	output logic [14:0]             gain_o,
	output logic [1:0]              select_o,
	// drive state
	output logic [1:0]              mode_o,
	output logic                    servo_en_o,
	output logic                    motor_cfg_o,
	output logic [12:0]             motor_max_o,
	output logic [12:0]             rated_o,
	// commands
	output logic signed [15:0]      cmd_o,
	output logic signed [15:0]      ref_o
);
	// idle values at time zero
	initial begin
		{setting_load_o, accel_o, decel_o, scurve_o, select_o} = '0;
		{mode_o, motor_cfg_o, cmd_o, ref_o} = '0;
		limit_o = 13'h1388;
		gain_o = speed_ramp_pkg::GAIN_DEF;
		servo_en_o = 1'b1;
		motor_max_o = 13'h0BB8;
		rated_o = 13'h03E8;
	end

	// one load pulse with servo dropped for that edge
	task automatic configure(input logic [15:0] acc, input logic [15:0] dec,
		input logic [12:0] sc, input logic [12:0] lim, input logic [14:0] gain,
		input logic [1:0] sel);
		logic en;
		en = servo_en_o;
		servo_en_o = 1'b0;
		scurve_o = (acc == 16'h0000 || dec == 16'h0000) ? 13'h0000 : sc;
		{accel_o, decel_o, limit_o, gain_o, select_o} = {acc, dec, lim, gain, sel};
		setting_load_o = 1'b1;
		@(posedge clock_i);
		#1;
		setting_load_o = 1'b0;
		servo_en_o = en;
		// let an edge pass so a following call starts clean
		@(posedge clock_i);
		#1;
	endtask

	// load attempt with servo left on
	task automatic load_servo_on(input logic [12:0] lim);
		servo_en_o = 1'b1;
		limit_o = lim;
		setting_load_o = 1'b1;
		@(posedge clock_i);
		#1;
		setting_load_o = 1'b0;
		// let an edge pass so a following call starts clean
		@(posedge clock_i);
		#1;
	endtask

	// motor model pulse
	task automatic motor(input logic [12:0] max);
		motor_max_o = max;
		motor_cfg_o = 1'b1;
		@(posedge clock_i);
		#1;
		motor_cfg_o = 1'b0;
		// let an edge pass so a following call starts clean
		@(posedge clock_i);
		#1;
	endtask

	// command levels
	task automatic drive(input logic [1:0] m, input logic signed [15:0] c,
		input logic signed [15:0] r);
		{mode_o, cmd_o, ref_o} = {m, c, r};
	endtask
endmodule

// File: tb/speed_ramp_limiter_tb.sv
// Purpose: self-checking bench for the speed ramp and limiter
// Assumes: one ramp tick every TICKS clocks
// Notes:   drivers queue notes, a watcher process compares them
`timescale 1ns/1ps
module speed_ramp_limiter_tb;
	localparam int unsigned TICKS = 100; // shortened tick
	typedef struct { logic [1:0] kind; logic [15:0] value; } note_t;
	logic clock_i = 1'b0;  // control clock
	logic resetn_i = 1'b0; // active low reset
	logic ld, mcfg, sen, lact, busy;
	logic [15:0] acc, dec;
	logic [12:0] sc, lim, mmax, rated, ilim;
	logic [14:0] gain;
	logic [1:0] sel, mode;
	logic signed [15:0] cmd, aref, sout;
	note_t notes_q[$];    // expected results
	note_t cur;           // note under compare
	logic [15:0] got;     // observed value
	event sample_ev;      // results are settled
	int miscompares = 0;
	int compares = 0;
	int n, m, gv, mv, ex, i;

	// 100 MHz clock
	always #5 clock_i = ~clock_i;

	host_model u_host (.clock_i(clock_i), .setting_load_o(ld), .accel_o(acc), .decel_o(dec),
		.scurve_o(sc), .limit_o(lim), .gain_o(gain), .select_o(sel), .mode_o(mode),
		.servo_en_o(sen), .motor_cfg_o(mcfg), .motor_max_o(mmax), .rated_o(rated),
		.cmd_o(cmd), .ref_o(aref));

	speed_ramp_limiter #(.TICK_CYCLES(TICKS)) u_dut (.clock_i(clock_i), .resetn_i(resetn_i),
		.setting_load_i(ld), .accel_time_setting_i(acc), .decel_time_setting_i(dec),
		.scurve_time_setting_i(sc), .internal_limit_setting_i(lim),
		.external_gain_setting_i(gain), .limit_select_setting_i(sel), .control_mode_i(mode),
		.servo_enable_i(sen), .motor_config_i(mcfg), .motor_max_speed_i(mmax),
		.rated_speed_i(rated), .speed_cmd_i(cmd), .analog_ref_i(aref), .speed_out_o(sout),
		.ramp_busy_o(busy), .limit_active_o(lact), .internal_limit_o(ilim));

	// watcher: oldest note against its output
	always @(sample_ev) begin
		while (notes_q.size() > 0) begin
			cur = notes_q.pop_front();
			case (cur.kind)
				2'h0: got = sout;
				2'h1: got = {3'h0, ilim};
				2'h2: got = {15'h0, lact};
				default: got = {15'h0, busy};
			endcase
			compares++;
			if (got !== cur.value) begin
				miscompares++;
				$display("ERROR t=%0t got=%h exp=%h", $time, got, cur.value);
			end
		end
	end

	task automatic cyc(input int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask

	// queue one note and let the watcher take it
	task automatic expect_val(input logic [1:0] k, input logic [15:0] v);
		notes_q.push_back('{k, v});
		-> sample_ev;
		#0;
	endtask

	// direct window check on a speed or a cycle count
	task automatic in_range(input logic signed [31:0] v, input int lo, input int hi);
		compares++;
		if ((v >= lo && v <= hi) !== 1'b1) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
		end
	endtask

	// wait for ramp completion, cycles counted
	task automatic settle(output int c);
		c = 3;
		cyc(3);
		while (busy !== 1'b0 && c < 60 * TICKS) begin
			cyc(1);
			c++;
		end
		// a ramp that never ends counts as a mismatch
		if (busy !== 1'b0) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, busy, 1'b0);
		end
		cyc(2);
	endtask

	task automatic final_report;
		#1;
		if (miscompares == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// watchdog
	initial begin
		#900000;
		miscompares++;
		final_report();
	end

	// main sequence
	initial begin
		void'($urandom(32'hA683));
		cyc(5);
		resetn_i = 1'b1;
		cyc(1);
		expect_val(2'h0, 16'h0000);
		expect_val(2'h1, 16'h1388);
		u_host.drive(speed_ramp_pkg::MODE_POSITION, 16'sh03E8, 16'sh0000);
		settle(n);
		expect_val(2'h0, 16'h03E8);
		expect_val(2'h3, 16'h0000);
		u_host.motor(13'h0BB8);
		expect_val(2'h1, 16'h0BB8);
		u_host.motor(13'h1770);
		expect_val(2'h1, 16'h1388);
		u_host.configure(16'h0, 16'h0, 13'h0, 13'h0000, 15'h1388, speed_ramp_pkg::LIM_INTERNAL);
		expect_val(2'h1, 16'h0001);
		u_host.configure(16'h0, 16'h0, 13'h0, 13'h0320, 15'h1388, speed_ramp_pkg::LIM_INTERNAL);
		u_host.load_servo_on(13'h0064);
		expect_val(2'h1, 16'h0320);
		u_host.drive(speed_ramp_pkg::MODE_POSITION, 16'sh04B0, 16'sh0000);
		settle(n);
		expect_val(2'h0, 16'h0320);
		expect_val(2'h2, 16'h0001);
		u_host.drive(speed_ramp_pkg::MODE_POSITION, -16'sh04B0, 16'sh0000);
		settle(n);
		expect_val(2'h0, -16'sh0320);
		// external limit, selection codes external, smaller and none
		u_host.drive(speed_ramp_pkg::MODE_TORQUE, 16'sh0BB8, -16'sh07D0);
		u_host.configure(16'h0, 16'h0, 13'h0, 13'h0320, 15'h1388, speed_ramp_pkg::LIM_EXTERNAL);
		settle(n);
		expect_val(2'h0, 16'h03E8);
		u_host.configure(16'h0, 16'h0, 13'h0, 13'h0320, 15'h1388, speed_ramp_pkg::LIM_SMALLER);
		settle(n);
		expect_val(2'h0, 16'h0320);
		u_host.configure(16'h0, 16'h0, 13'h0, 13'h0320, 15'h1388, speed_ramp_pkg::LIM_NONE);
		settle(n);
		expect_val(2'h0, 16'h0BB8);
		expect_val(2'h2, 16'h0000);
		// random gain and reference in the limiting modes
		for (i = 0; i < 6; i++) begin
			gv = 100 + ($urandom % 19901);
			mv = int'($urandom % 20001) - 10000;
			ex = gv * (mv < 0 ? -mv : mv) / 10000;
			ex = (ex < 4000) ? ex : 4000;
			u_host.drive((i % 3 == 0) ? 2'h0 : 2'(1 + i % 3), (i % 2) ? -16'sd4000 : 16'sd4000,
				16'(mv));
			u_host.configure(16'h0, 16'h0, 13'h0, 13'h1388, 15'(gv), speed_ramp_pkg::LIM_EXTERNAL);
			settle(n);
			expect_val(2'h0, (i % 2) ? 16'(-ex) : 16'(ex));
		end
		// speed mode: analog is the command
		u_host.drive(speed_ramp_pkg::MODE_SPEED, 16'sh0000, 16'sh0BB8);
		u_host.configure(16'h0, 16'h0, 13'h0, 13'h0320, 15'h1388, speed_ramp_pkg::LIM_EXTERNAL);
		settle(n);
		expect_val(2'h0, 16'h05DC);
		u_host.drive(speed_ramp_pkg::MODE_SPEED, 16'sh0000, -16'sh0BB8);
		settle(n);
		expect_val(2'h0, -16'sh05DC);
		u_host.configure(16'h0, 16'h0, 13'h0, 13'h0320, 15'h1388, speed_ramp_pkg::LIM_SMALLER);
		settle(n);
		expect_val(2'h0, -16'sh0320);
		// linear ramps, rated 1000 rpm: 100 rpm per tick up, 50 down
		u_host.drive(speed_ramp_pkg::MODE_POSITION, 16'sh0000, 16'sh0000);
		u_host.configure(16'd10, 16'd20, 13'h0, 13'h1388, 15'h1388, speed_ramp_pkg::LIM_NONE);
		settle(n);
		cyc(3 * TICKS);
		u_host.drive(speed_ramp_pkg::MODE_POSITION, 16'sh03E8, 16'sh0000);
		cyc(5 * TICKS);
		in_range(sout, 300, 600);
		expect_val(2'h3, 16'h0001);
		settle(n);
		in_range(n + 5 * TICKS, 9 * TICKS, 12 * TICKS);
		expect_val(2'h0, 16'h03E8);
		m = n + 5 * TICKS;
		u_host.drive(speed_ramp_pkg::MODE_POSITION, 16'sh0000, 16'sh0000);
		settle(n);
		in_range(n, 19 * TICKS, 22 * TICKS);
		// S-curve of 5 ms on the same ramps
		u_host.configure(16'd10, 16'd20, 13'd5, 13'h1388, 15'h1388, speed_ramp_pkg::LIM_NONE);
		cyc(3 * TICKS);
		u_host.drive(speed_ramp_pkg::MODE_POSITION, 16'sh03E8, 16'sh0000);
		cyc(2 * TICKS);
		in_range(sout, 0, 99);
		settle(n);
		in_range(n + 2 * TICKS, m + 1, m + 8 * TICKS);
		expect_val(2'h0, 16'h03E8);
		// second reset in mid-run: defaults come back
		resetn_i = 1'b0;
		cyc(2);
		resetn_i = 1'b1;
		cyc(1);
		expect_val(2'h0, 16'h0000);
		expect_val(2'h1, 16'h1388);
		expect_val(2'h3, 16'h0000);
		settle(n);
		expect_val(2'h0, 16'h03E8);
		final_report();
	end
endmodule
